// ==== core/lsfr_pkg.sv ====
// Shared constants, types and helpers for the link frame router
package lsfr_pkg;

  // Clock tree: 8 MHz resonator, 1 MHz logic tick
  localparam int OSC_MHZ = 8;
  localparam int TICK_MHZ = 1;
  localparam int OSC_PER_TICK = OSC_MHZ / TICK_MHZ;

  // Frame timing in microseconds, converted to 1 MHz ticks
  localparam int BIT_US = 10;
  localparam int GAP_US = 4;
  localparam int BIT_TICKS = BIT_US * TICK_MHZ;
  localparam int GAP_TICKS = GAP_US * TICK_MHZ;
  localparam int HALF_TICKS = BIT_TICKS / 2;
  localparam int FRAME_BITS = 15;
  localparam int NMI_TICKS = 16;

  // Wire bit positions, first bit sent at index 0
  localparam int POS_START = 0;
  localparam int POS_DATA = 1;
  localparam int POS_ADDR = 9;
  localparam int POS_CMD = 12;
  localparam int POS_PARITY = 13;
  localparam int POS_STOP = 14;

  localparam logic [2:0] UNIVERSAL_ADDR = 3'h0;
  localparam logic [2:0] RESET_MATCH_ADDR = 3'h0;
  localparam logic RESET_POWERUP = 1'b1;
  localparam logic RESET_FWD_MODE = 1'b0;

  // Register view: command bit left of the address
  typedef struct packed {
    logic cmd;
    logic [2:0] addr;
    logic [7:0] data;
  } lsfr_frame_s;

  typedef struct packed {
    logic [2:0] match_addr;
    logic fwd_mode;
    logic powerup;
  } lsfr_cfg_s;

  // Wire view: data, address, then command, parity and stop
  function automatic logic [14:0] lsfr_wire_bits(input lsfr_frame_s f);
    return {1'b1, ^f, f.cmd, f.addr, f.data, 1'b0};
  endfunction : lsfr_wire_bits

endpackage : lsfr_pkg

// ==== core/lsfr_frame_tx.sv ====
// Serial frame transmitter timed by the 1 MHz tick
`timescale 1ns/1ps
module lsfr_frame_tx import lsfr_pkg::*; #(
  parameter int BIT_LEN = BIT_TICKS,
  parameter int GAP_LEN = GAP_TICKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire lsfr_frame_s frame,
  input wire logic valid,
  output logic ready,
  output logic line
);

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SHIFT = 3'b010,
    TX_GAP = 3'b100
  } lsfr_tx_e;

  // Counters are four bits wide
  if (BIT_LEN < 2 || BIT_LEN > 15 || GAP_LEN < 1 || GAP_LEN > 15) begin : g_bad_timing
    $error("lsfr_frame_tx: timing out of range");
  end

  lsfr_tx_e state;
  logic [14:0] shift;
  logic [3:0] cnt;
  logic [3:0] bitn;

  // Start only on a tick so the start bit is a full period
  assign ready = (state == TX_IDLE) && tick;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= TX_IDLE;
      shift <= 15'h7FFF;
      cnt <= 4'h0;
      bitn <= 4'h0;
      line <= 1'b1;
    end else begin
      case (state)
        TX_IDLE: begin
          if (valid && ready) begin
            shift <= lsfr_wire_bits(frame);
            line <= 1'b0;
            cnt <= 4'h0;
            bitn <= 4'h0;
            state <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (tick) begin
            if (cnt == 4'(BIT_LEN - 1)) begin
              cnt <= 4'h0;
              if (bitn == 4'(FRAME_BITS - 1)) begin
                line <= 1'b1;
                state <= TX_GAP;
              end else begin
                bitn <= bitn + 4'h1;
                line <= shift[bitn + 4'h1];
              end
            end else begin
              cnt <= cnt + 4'h1;
            end
          end
        end
        TX_GAP: begin
          if (tick) begin
            if (cnt == 4'(GAP_LEN - 1)) begin
              state <= TX_IDLE;
            end else begin
              cnt <= cnt + 4'h1;
            end
          end
        end
        default: state <= TX_IDLE;
      endcase
    end
  end

  property p_tx_start_low;
    @(posedge clk) disable iff (!rst_n) (valid && ready) |=> !line && state == TX_SHIFT;
  endproperty
  a_tx_start_low: assert property (p_tx_start_low) else $error("start bit not low");

  property p_tx_bit_stable;
    @(posedge clk) disable iff (!rst_n)
      (state == TX_SHIFT && !(tick && cnt == 4'(BIT_LEN - 1))) |=> $stable(line);
  endproperty
  a_tx_bit_stable: assert property (p_tx_bit_stable) else $error("bit changed early");

  property p_tx_gap_idle;
    @(posedge clk) disable iff (!rst_n) (state == TX_GAP) |-> line && !ready;
  endproperty
  a_tx_gap_idle: assert property (p_tx_gap_idle) else $error("gap not idle high");

  c_tx_frame: cover property (@(posedge clk) disable iff (!rst_n)
    state == TX_GAP ##1 state == TX_IDLE);

endmodule : lsfr_frame_tx

// ==== core/lsfr_router.sv ====
// Device-side link frame router: receive, route, interrupt, reset and clocks
// Functional notes
// - Frame is exactly fifteen bits
// - Each bit lasts ten microseconds
// - Idle high, low start, high stop
// - At least four microseconds idle between frames
// - Odd parity over all fifteen bits, checked
// - Forward mode retransmits upstream frames downstream
// - Forward mode buffers return input straight to return output
// - Turnaround mode sends processed frames out return
// - Interrupt only on address match or error
// - Processor reset low at power-up and command
// - 8 MHz halved to 4 MHz processor clock
// - Own logic runs from 1 MHz tick
// - Return output drives upstream return or host
// - Reset: address zero, power-up set, turnaround
// - Three-bit address, zero is universal
// - Command bit left of address in registers
`timescale 1ns/1ps
module lsfr_router import lsfr_pkg::*; #(
  parameter logic [7:0] HARD_RESET_OP = 8'h0F,
  parameter int NMI_LEN = NMI_TICKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic osc_in,
  output logic cpu_clk,
  output logic nmi_n,
  input wire logic link_in,
  output logic link_out,
  input wire logic return_input,
  output logic return_output,
  output logic irq,
  input wire logic irq_ack,
  output lsfr_frame_s host_frame,
  output logic host_err,
  input wire lsfr_frame_s tx_frame,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic cfg_we,
  input wire lsfr_cfg_s cfg_in,
  output lsfr_cfg_s cfg_state
);

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_START = 3'b010,
    RX_BITS = 3'b100
  } lsfr_rx_e;

  // Hold counter is five bits wide
  if (NMI_LEN < 1 || NMI_LEN > 31) begin : g_bad_nmi_len
    $error("lsfr_router: NMI_LEN out of range");
  end

  logic rst_a;
  logic rst_q;
  logic osc_a, osc_b, osc_c;
  logic in_a, in_b, in_c;
  logic ret_a, ret_b;
  logic [2:0] osc_cnt;
  logic tick;
  logic osc_rise;
  lsfr_rx_e rx_state;
  logic [3:0] rx_cnt;
  logic [3:0] rx_bitn;
  logic [14:0] rx_word;
  logic rx_done;
  lsfr_frame_s rx_frame;
  logic rx_err;
  logic rx_match;
  logic hard_cmd;
  logic [4:0] nmi_cnt;
  lsfr_frame_s fwd_frame;
  logic fwd_pend;
  logic txr_ready;
  logic tx_line;
  lsfr_frame_s txr_frame;
  logic txr_valid;

  // Reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_a <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_q <= rst_a;
    end
  end

  // Pin synchronisers; second stage feeds logic, third stage (osc_c, in_c) only for edge detection
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      osc_a <= 1'b0;
      osc_b <= 1'b0;
      osc_c <= 1'b0;
      in_a <= 1'b1;
      in_b <= 1'b1;
      in_c <= 1'b1;
      ret_a <= 1'b1;
      ret_b <= 1'b1;
    end else begin
      osc_a <= osc_in;
      osc_b <= osc_a;
      osc_c <= osc_b;
      in_a <= link_in;
      in_b <= in_a;
      in_c <= in_b;
      ret_a <= return_input;
      ret_b <= ret_a;
    end
  end

  assign osc_rise = osc_b && !osc_c;
  assign tick = osc_rise && (osc_cnt == 3'(OSC_PER_TICK - 1));

  // Clock dividers follow resonator edges, not the fast clock
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      cpu_clk <= 1'b0;
      osc_cnt <= 3'h0;
    end else if (osc_rise) begin
      cpu_clk <= !cpu_clk;
      osc_cnt <= osc_cnt + 3'h1;
    end
  end

  // Receiver: half-bit wait confirms start, then one sample per bit
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      rx_state <= RX_IDLE;
      rx_cnt <= 4'h0;
      rx_bitn <= 4'h0;
      rx_word <= 15'h7FFF;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          if (in_c && !in_b) begin
            rx_cnt <= 4'h0;
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (tick) begin
            if (rx_cnt == 4'(HALF_TICKS - 1)) begin
              rx_cnt <= 4'h0;
              rx_bitn <= 4'h1;
              rx_word[POS_START] <= in_b;
              rx_state <= in_b ? RX_IDLE : RX_BITS;
            end else begin
              rx_cnt <= rx_cnt + 4'h1;
            end
          end
        end
        RX_BITS: begin
          if (tick) begin
            if (rx_cnt == 4'(BIT_TICKS - 1)) begin
              rx_cnt <= 4'h0;
              rx_word[rx_bitn] <= in_b;
              rx_bitn <= rx_bitn + 4'h1;
              if (rx_bitn == 4'(FRAME_BITS - 1)) begin
                rx_done <= 1'b1;
                rx_state <= RX_IDLE;
              end
            end else begin
              rx_cnt <= rx_cnt + 4'h1;
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // Command bit comes after the address on the wire, left of it here
  assign rx_frame = lsfr_frame_s'(rx_word[POS_CMD:POS_DATA]);
  assign rx_err = !rx_word[POS_STOP] || !(^rx_word);
  assign rx_match = (rx_frame.addr == cfg_state.match_addr)
                    || (rx_frame.addr == UNIVERSAL_ADDR);
  assign hard_cmd = rx_done && !rx_err && rx_match && rx_frame.cmd
                    && (rx_frame.data == HARD_RESET_OP);

  // Configuration held by the local processor
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      cfg_state.match_addr <= RESET_MATCH_ADDR;
      cfg_state.fwd_mode <= RESET_FWD_MODE;
      cfg_state.powerup <= RESET_POWERUP;
    end else if (cfg_we) begin
      cfg_state.match_addr <= cfg_in.match_addr;
      cfg_state.fwd_mode <= cfg_in.fwd_mode;
      cfg_state.powerup <= cfg_in.powerup && cfg_state.powerup;
    end
  end

  // Interrupt holds until acknowledged; a new event beats the ack
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      irq <= 1'b0;
      host_frame <= '0;
      host_err <= 1'b0;
    end else if (rx_done && (rx_err || rx_match)) begin
      irq <= 1'b1;
      host_frame <= rx_frame;
      host_err <= rx_err;
    end else if (irq_ack) begin
      irq <= 1'b0;
    end
  end

  // Frames for others pass on untouched; bad frames are dropped
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      fwd_pend <= 1'b0;
      fwd_frame <= '0;
    end else if (rx_done && !rx_err && !rx_match) begin
      fwd_pend <= 1'b1;
      fwd_frame <= rx_frame;
    end else if (txr_ready) begin
      fwd_pend <= 1'b0;
    end
  end

  // Pass-on traffic first; processor frames wait behind it
  assign txr_valid = fwd_pend || tx_valid;
  assign txr_frame = fwd_pend ? fwd_frame : tx_frame;
  assign tx_ready = txr_ready && !fwd_pend;

  lsfr_frame_tx #(
    .BIT_LEN(BIT_TICKS),
    .GAP_LEN(GAP_TICKS)
  ) u_tx (
    .clk(clk),
    .rst_n(rst_q),
    .tick(tick),
    .frame(txr_frame),
    .valid(txr_valid),
    .ready(txr_ready),
    .line(tx_line)
  );

  // Mode switch mid-frame can cut a frame; software switches when idle
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      link_out <= 1'b1;
      return_output <= 1'b1;
    end else begin
      link_out <= cfg_state.fwd_mode ? tx_line : 1'b1;
      return_output <= cfg_state.fwd_mode ? ret_b : tx_line;
    end
  end

  // Processor reset: low through reset and for a while after
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      nmi_cnt <= 5'(NMI_LEN);
      nmi_n <= 1'b0;
    end else begin
      if (hard_cmd) begin
        nmi_cnt <= 5'(NMI_LEN);
      end else if (tick && nmi_cnt != 5'h00) begin
        nmi_cnt <= nmi_cnt - 5'h01;
      end
      nmi_n <= (nmi_cnt == 5'h00) && !hard_cmd;
    end
  end

  property p_reset_cfg;
    @(posedge clk) $rose(rst_q) |-> cfg_state.match_addr == RESET_MATCH_ADDR
      && cfg_state.powerup && !cfg_state.fwd_mode && !nmi_n;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("bad reset state");

  property p_nmi_cmd;
    @(posedge clk) disable iff (!rst_q) hard_cmd |=> !nmi_n [*3];
  endproperty
  a_nmi_cmd: assert property (p_nmi_cmd) else $error("nmi not driven low");

  property p_irq_cause;
    @(posedge clk) disable iff (!rst_q) $rose(irq) |-> $past(rx_done && (rx_err || rx_match));
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");

  property p_irq_set;
    @(posedge clk) disable iff (!rst_q)
      rx_done && (rx_err || rx_match) |=> irq && host_frame == $past(rx_frame);
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("event not flagged");

  property p_parity;
    @(posedge clk) disable iff (!rst_q) rx_done && rx_word[POS_STOP] && !(^rx_word) |=> host_err;
  endproperty
  a_parity: assert property (p_parity) else $error("parity error missed");

  property p_pass_on;
    @(posedge clk) disable iff (!rst_q)
      rx_done && !rx_err && !rx_match |=> fwd_pend && !$rose(irq);
  endproperty
  a_pass_on: assert property (p_pass_on) else $error("frame not passed on");

  property p_return_buf;
    @(posedge clk) disable iff (!rst_q)
      cfg_state.fwd_mode && $past(cfg_state.fwd_mode) |-> return_output == $past(ret_b);
  endproperty
  a_return_buf: assert property (p_return_buf) else $error("return path altered");

  property p_turnaround;
    @(posedge clk) disable iff (!rst_q) !cfg_state.fwd_mode |=> link_out;
  endproperty
  a_turnaround: assert property (p_turnaround) else $error("downstream driven");

  property p_cpu_clk;
    @(posedge clk) disable iff (!rst_q) osc_rise |=> cpu_clk != $past(cpu_clk);
  endproperty
  a_cpu_clk: assert property (p_cpu_clk) else $error("cpu clock not divided");

  // Separate count of resonator edges, so the divider is checked from outside
  logic [3:0] osc_seen;
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      osc_seen <= 4'h0;
    end else if (tick) begin
      osc_seen <= 4'h0;
    end else if (osc_rise) begin
      osc_seen <= osc_seen + 4'h1;
    end
  end

  property p_tick_rate;
    @(posedge clk) disable iff (!rst_q) osc_rise |-> tick == (osc_seen == 4'(OSC_PER_TICK - 1));
  endproperty
  a_tick_rate: assert property (p_tick_rate) else $error("tick rate wrong");

  c_match: cover property (@(posedge clk) disable iff (!rst_q) rx_done && rx_match && !rx_err);
  c_error: cover property (@(posedge clk) disable iff (!rst_q) rx_done && rx_err);
  c_hard: cover property (@(posedge clk) disable iff (!rst_q) hard_cmd);
  c_fwd: cover property (@(posedge clk) disable iff (!rst_q) fwd_pend && txr_ready);

endmodule : lsfr_router

// ==== tb/lsfr_link_peer.sv ====
// Link partner model: frame sender and bit-centre frame receiver
`timescale 1ns/1ps
module lsfr_link_peer (
  input wire logic rx_line,
  output logic tx_line,
  output logic [14:0] rx_word,
  output logic rx_stb
);
  initial begin
    tx_line = 1'b1;
    rx_word = 15'h0000;
    rx_stb = 1'b0;
  end

  // Caller builds start, parity and stop into w
  task automatic send(input logic [14:0] w);
    for (int i = 0; i < 15; i++) begin
      tx_line = w[i];
      #10000;
    end
    tx_line = 1'b1;
    #4000;
  endtask : send

  // Far side samples mid-bit, timed from the start edge
  always begin
    @(negedge rx_line);
    #5000;
    if (rx_line === 1'b0) begin
      for (int i = 0; i < 15; i++) begin
        rx_word[i] = rx_line;
        if (i < 14) #10000;
      end
      rx_stb = 1'b1;
      #1;
      rx_stb = 1'b0;
    end
  end
endmodule : lsfr_link_peer

// ==== tb/link_slave_frame_router_tb_top.sv ====
// Self-checking bench for the link frame router
`timescale 1ns/1ps
module link_slave_frame_router_tb_top import lsfr_pkg::*;;
  localparam logic [7:0] HR_OP = 8'h0F;
  logic clk = 1'b0;
  logic osc_in = 1'b0;
  logic rst_n = 1'b0;
  logic irq_ack = 1'b0;
  logic tx_valid = 1'b0;
  logic cfg_we = 1'b0;
  lsfr_frame_s tx_frame = '0;
  lsfr_cfg_s cfg_in = '0;
  logic cpu_clk, nmi_n, link_in, link_out, return_input, return_output;
  logic irq, host_err, tx_ready, up_stb, dn_stb;
  logic [14:0] up_word, dn_word;
  lsfr_frame_s host_frame;
  lsfr_cfg_s cfg_state;
  logic [14:0] exp_up[$];
  logic [14:0] exp_dn[$];
  logic [12:0] exp_irq[$];
  int n_fail = 0;
  int num_checks = 0;
  int n_nmi = 0;
  int n_cpu = 0;
  int cycles = 0;
  logic [31:0] rng = 32'h00000019;

  always #4 clk = ~clk;
  always #62.5 osc_in = ~osc_in;

  lsfr_router #(.HARD_RESET_OP(HR_OP), .NMI_LEN(2)) dut (
    .clk(clk), .rst_n(rst_n), .osc_in(osc_in), .cpu_clk(cpu_clk), .nmi_n(nmi_n),
    .link_in(link_in), .link_out(link_out), .return_input(return_input),
    .return_output(return_output), .irq(irq), .irq_ack(irq_ack),
    .host_frame(host_frame), .host_err(host_err), .tx_frame(tx_frame),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .cfg_we(cfg_we), .cfg_in(cfg_in),
    .cfg_state(cfg_state)
  );
  lsfr_link_peer up (.rx_line(return_output), .tx_line(link_in), .rx_word(up_word),
    .rx_stb(up_stb));
  lsfr_link_peer dn (.rx_line(link_out), .tx_line(return_input), .rx_word(dn_word),
    .rx_stb(dn_stb));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // Odd count of ones over all fifteen bits unless bad is set
  function automatic logic [14:0] wire_word(input lsfr_frame_s f, input logic bad);
    return {1'b1, (^f) ^ bad, f.cmd, f.addr, f.data, 1'b0};
  endfunction : wire_word

  function automatic lsfr_frame_s mk(input logic c, input logic [2:0] a);
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return '{cmd: c, addr: a, data: rng[7:0]};
  endfunction : mk

  task automatic cfg_write(input lsfr_cfg_s c);
    @(negedge clk);
    cfg_in = c;
    cfg_we = 1'b1;
    @(negedge clk);
    cfg_we = 1'b0;
  endtask : cfg_write

  // Request held until tx_ready is seen at a rising edge
  task automatic tx_send(input lsfr_frame_s f);
    int n;
    n = 0;
    @(negedge clk);
    tx_frame = f;
    tx_valid = 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (tx_ready !== 1'b1 && n < 25000);
    @(negedge clk);
    tx_valid = 1'b0;
    check("tx handshake", 16'h0001, {15'h0000, n < 25000});
  endtask : tx_send

  always @(negedge nmi_n) n_nmi++;
  always @(posedge cpu_clk) n_cpu++;

  always @(posedge up_stb) begin
    if (exp_up.size() == 0) check("return_output unexpected", 16'h0000, 16'h0001);
    else check("return_output frame", {1'b0, exp_up.pop_front()}, {1'b0, up_word});
  end

  always @(posedge dn_stb) begin
    if (exp_dn.size() == 0) check("link_out unexpected", 16'h0000, 16'h0001);
    else check("link_out frame", {1'b0, exp_dn.pop_front()}, {1'b0, dn_word});
  end

  always @(posedge irq) begin
    @(negedge clk);
    if (exp_irq.size() == 0) check("irq unexpected", 16'h0000, 16'h0001);
    else check("host frame", {3'h0, exp_irq.pop_front()}, {3'h0, host_err, host_frame});
    irq_ack = 1'b1;
    @(negedge clk);
    irq_ack = 1'b0;
  end

  // Run needs about 82000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    lsfr_frame_s a, b, c, p, r, u;
    int n0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    check("cfg after reset", 16'h0001, {11'h000, cfg_state});
    check("nmi_n at release", 16'h0000, {15'h0000, nmi_n});
    repeat (625) @(negedge clk);
    check("nmi_n after hold", 16'h0001, {15'h0000, nmi_n});
    n0 = n_cpu;
    repeat (1000) @(negedge clk);
    check("cpu_clk rises in 8 us", 16'h0020, 16'(n_cpu - n0));
    $display("test reset done");

    p = mk(1'b0, 3'h1);
    u = mk(1'b0, 3'h0);
    exp_up.push_back(wire_word(p, 1'b0));
    exp_irq.push_back({1'b0, u});
    fork
      tx_send(p);
      up.send(wire_word(u, 1'b0));
    join
    repeat (1000) @(negedge clk);
    $display("test turnaround done");

    cfg_write('{match_addr: 3'h3, fwd_mode: 1'b1, powerup: 1'b0});
    @(negedge clk);
    check("cfg written", 16'h000E, {11'h000, cfg_state});
    a = mk(1'b0, 3'h5);
    r = mk(1'b1, 3'h2);
    exp_dn.push_back(wire_word(a, 1'b0));
    exp_up.push_back(wire_word(r, 1'b0));
    fork
      up.send(wire_word(a, 1'b0));
      dn.send(wire_word(r, 1'b0));
    join
    $display("test forward and return done");

    b = '{cmd: 1'b1, addr: 3'h3, data: HR_OP};
    exp_irq.push_back({1'b0, b});
    n0 = n_nmi;
    up.send(wire_word(b, 1'b0));
    check("nmi pulses", 16'h0001, 16'(n_nmi - n0));
    $display("test hard reset done");

    c = mk(1'b0, 3'h6);
    exp_irq.push_back({1'b1, c});
    up.send(wire_word(c, 1'b1));
    repeat (2500) @(negedge clk);
    check("outputs outstanding", 16'h0000,
      16'(exp_up.size() + exp_dn.size() + exp_irq.size()));
    $display("test parity error done");
    end_of_test();
  end
endmodule : link_slave_frame_router_tb_top
